// File: core/rdsc_map.svh
`ifndef RDSC_MAP_SVH
`define RDSC_MAP_SVH
// system clock period
`define RDSC_SYS_PERIOD_NS 50
// word length on the link
`define RDSC_WORD_BITS 8
// chip select low to first serial clock edge, least
`define RDSC_LEAD_NS 10
`define RDSC_LEAD_CYC ((`RDSC_LEAD_NS + `RDSC_SYS_PERIOD_NS - 1) / `RDSC_SYS_PERIOD_NS)
// last serial clock fall to chip select high, least
`define RDSC_TAIL_NS 80
`define RDSC_TAIL_CYC ((`RDSC_TAIL_NS + `RDSC_SYS_PERIOD_NS - 1) / `RDSC_SYS_PERIOD_NS)
// idle gap between two words, least
`define RDSC_GAP_NS 170
`define RDSC_GAP_CYC ((`RDSC_GAP_NS + `RDSC_SYS_PERIOD_NS - 1) / `RDSC_SYS_PERIOD_NS)
// half period of the serial clock made by the host
`define RDSC_HALF_NS 200
`define RDSC_HALF_CYC ((`RDSC_HALF_NS + `RDSC_SYS_PERIOD_NS - 1) / `RDSC_SYS_PERIOD_NS)
// least spacing of two register rewrites (twice 5 kHz)
`define RDSC_SPACING_US 100
`define RDSC_SPACING_CYC ((`RDSC_SPACING_US * 1000 + `RDSC_SYS_PERIOD_NS - 1) / `RDSC_SYS_PERIOD_NS)
// host register byte offsets
`define RDSC_REG_TXDATA 12'h000
`define RDSC_REG_CFG 12'h004
`define RDSC_REG_STATUS 12'h008
// field positions
`define RDSC_CFG_FORCE_BIT 0
`define RDSC_STAT_BUSY_BIT 0
`define RDSC_STAT_CNT_LSB 8
// reset value of the output control register
`define RDSC_OUT_RESET 8'h00
// synchroniser reset levels: lane 0 is chip select, idle high
`define RDSC_SYNC_IDLE 4'h1
`endif

// File: core/rdsc_pkg.sv
package rdsc_pkg;
  // one serial word
  typedef logic [7:0] rdsc_word_t;
  // receiver states, gray along idle -> shift -> latch
  typedef enum logic [1:0] {
    RDSC_DEV_IDLE  = 2'b00,
    RDSC_DEV_SHIFT = 2'b01,
    RDSC_DEV_LATCH = 2'b11
  } rdsc_dev_state_t;
  // sender states, gray on every step of the frame path except high -> tail and gap -> idle
  typedef enum logic [2:0] {
    RDSC_HST_IDLE = 3'b000,
    RDSC_HST_LEAD = 3'b001,
    RDSC_HST_HIGH = 3'b011,
    RDSC_HST_LOW  = 3'b010,
    RDSC_HST_TAIL = 3'b110,
    RDSC_HST_GAP  = 3'b111
  } rdsc_hst_state_t;
endpackage

// File: core/rdsc_if.sv
`timescale 1ns/1ps
// ---------------------------------------------
// serial link between host and relay driver
// ---------------------------------------------
interface rdsc_if;
  logic chip_select_n;     // active low frame select
  logic serial_clk;        // clock made by the host, idles low
  logic serial_data;       // data, msb first
  logic low_side_output_1_force_enable; // forces output 1 on when high
  // relay driver end
  modport dev (
    input chip_select_n,
    input serial_clk,
    input serial_data,
    input low_side_output_1_force_enable
  );
  // host end
  modport hst (
    output chip_select_n,
    output serial_clk,
    output serial_data,
    output low_side_output_1_force_enable
  );
endinterface

// File: core/rdsc_sync.sv
`timescale 1ns/1ps
// ---------------------------------------------
// two flop synchroniser, one lane per pin
// ---------------------------------------------
module rdsc_sync (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic [3:0] i_async,
  output logic      [3:0] o_sync
);
`include "rdsc_map.svh"

  // reset level per lane, so release shows an idle link
  localparam logic [3:0] IDLE_LVL = `RDSC_SYNC_IDLE;
  logic [3:0] meta_q; // first stage, read only by the second
  logic [3:0] sync_q; // second stage

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      // both stages reset to the lane's idle level; a low
      // chip select here would read as a frame opening
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          meta_q[g] <= IDLE_LVL[g];
          sync_q[g] <= IDLE_LVL[g];
        end else begin
          meta_q[g] <= i_async[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign o_sync = sync_q;
endmodule

// File: core/rdsc_device.sv
`timescale 1ns/1ps
// Operation
// - take 8-bit words on host serial clock
// - one control register holds all outputs
// - ignore clock and data while deselected
// - host waits lead time before clocking
// - select rising edge loads shifted word
// - host keeps serial clock low between frames
// - host leaves idle gap between words
// - bit n drives output n+1, reset off
// - host rewrites no faster than 10 kHz
module rdsc_device
  import rdsc_pkg::*;
(
  input  wire logic       I_SYS_CLK,
  input  wire logic       I_ARST_N,
  rdsc_if.dev             LINK,
  output logic      [7:0] O_LOW_SIDE_OUT,
  output logic            O_WORD_LOADED,
  output logic            O_FRAME_ERR
);
`include "rdsc_map.svh"

  // ---------------------------------------------
  // pin synchronisers
  // ---------------------------------------------
  logic [3:0] pins_s;      // synchronised pins
  logic       cs_n_s;      // chip select, active low
  logic       sclk_s;      // serial clock
  logic       sdata_s;     // serial data
  logic       force_s;     // output 1 force enable

  // all four pins share one latency, so data and
  // clock stay aligned after the crossing
  // limitation: the link clock is sampled, not used as a
  // clock, so each high and low phase must span two system
  // clocks or an edge is lost and the frame drops as short
  rdsc_sync u_sync (
    .i_clk    (I_SYS_CLK),
    .i_arst_n (I_ARST_N),
    .i_async  ({LINK.low_side_output_1_force_enable, LINK.serial_data,
                LINK.serial_clk, LINK.chip_select_n}),
    .o_sync   (pins_s)
  );

  assign cs_n_s  = pins_s[0];
  assign sclk_s  = pins_s[1];
  assign sdata_s = pins_s[2];
  assign force_s = pins_s[3];

  // ---------------------------------------------
  // edge detection
  // ---------------------------------------------
  logic cs_n_prev_q;  // chip select one cycle ago
  logic sclk_prev_q;  // serial clock one cycle ago
  logic cs_fall;      // frame opens
  logic cs_rise;      // frame closes
  logic sclk_rise;    // data sampling edge

  // chip select resets high so reset release is no frame start
  // the synchroniser resets that lane high as well, so the
  // first edges after reset see an idle, deselected link
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cs_n_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else begin
      cs_n_prev_q <= cs_n_s;
      sclk_prev_q <= sclk_s;
    end
  end

  assign cs_fall   = cs_n_prev_q & ~cs_n_s;
  assign cs_rise   = ~cs_n_prev_q & cs_n_s;
  // the clock idles low, so its rising edge samples data
  assign sclk_rise = ~sclk_prev_q & sclk_s;

  // ---------------------------------------------
  // frame state machine
  // ---------------------------------------------
  rdsc_dev_state_t state_q; // current state
  rdsc_dev_state_t state_d; // next state

  // data never steers the state; a stray select rise while
  // idle is ignored, so only a framed word reaches latch
  // next state from the select edges only
  always_comb begin
    state_d = state_q;
    case (state_q)
      // wait for the host to open a frame
      RDSC_DEV_IDLE: begin
        if (cs_fall) begin
          state_d = RDSC_DEV_SHIFT;
        end
      end
      // collect bits until select goes high again
      RDSC_DEV_SHIFT: begin
        if (cs_rise) begin
          state_d = RDSC_DEV_LATCH;
        end
      end
      // one cycle to move the word into the register
      RDSC_DEV_LATCH: begin
        if (cs_fall) begin
          state_d = RDSC_DEV_SHIFT;
        end else begin
          state_d = RDSC_DEV_IDLE;
        end
      end
      default: begin
        state_d = RDSC_DEV_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_q <= RDSC_DEV_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------
  // shift register and bit count
  // ---------------------------------------------
  rdsc_word_t shift_q; // bits taken so far, msb first
  logic [3:0] count_q; // bits taken, saturates at 15
  // the count saturates so an overlong frame never wraps
  // back to eight and passes as a good word

  // gate by select
  // a clock edge counts only while selected and shifting;
  // stray edges while deselected leave the word untouched
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      shift_q <= 8'h00;
      count_q <= 4'h0;
    end else if (cs_fall) begin
      // new frame: forget any partial word
      shift_q <= 8'h00;
      count_q <= 4'h0;
    end else if ((state_q == RDSC_DEV_SHIFT) && !cs_n_s && sclk_rise) begin
      shift_q <= {shift_q[6:0], sdata_s};
      if (count_q != 4'hf) begin
        count_q <= count_q + 4'h1;
      end
    end
  end

  // ---------------------------------------------
  // output control register
  // ---------------------------------------------
  rdsc_word_t ctrl_q;      // the single control register
  logic       word_ok;     // exactly one full word arrived

  assign word_ok = (count_q == 4'(`RDSC_WORD_BITS));

  // the load decision, shared by the register and its pulse
  function automatic logic load_word(input rdsc_dev_state_t st, input logic full);
    load_word = (st == RDSC_DEV_LATCH) && full;
  endfunction

  // load on select rise
  // a frame with a wrong bit count is dropped whole, since
  // a partial word would switch relays the host never meant
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ctrl_q <= `RDSC_OUT_RESET;
    end else if (load_word(state_q, word_ok)) begin
      ctrl_q <= shift_q;
    end
  end

  // frame result pulses, one cycle each
  // the error pulse lets the system notice a host that
  // closed a frame early or clocked too many bits
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_WORD_LOADED <= 1'b0;
      O_FRAME_ERR   <= 1'b0;
    end else begin
      O_WORD_LOADED <= load_word(state_q, word_ok);
      O_FRAME_ERR   <= (state_q == RDSC_DEV_LATCH) && !word_ok;
    end
  end

  // ---------------------------------------------
  // output drivers
  // ---------------------------------------------
  // outputs are registered so a pin glitch never reaches
  // a relay; costs one cycle of latency
  // output 8 sits on bit 7 and output 1 on bit 0
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_LOW_SIDE_OUT <= `RDSC_OUT_RESET;
    end else begin
      O_LOW_SIDE_OUT[7:1] <= ctrl_q[7:1];
      // force output one
      // a floating enable is expected to read low here
      O_LOW_SIDE_OUT[0]   <= ctrl_q[0] | force_s;
    end
  end
endmodule

// File: core/rdsc_host.sv
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// ---------------------------------------------
// host end: apb slave that sends words on the link
// ---------------------------------------------
module rdsc_host
  import rdsc_pkg::*;
(
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_ARST_N,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  rdsc_if.hst              LINK
);
`include "rdsc_map.svh"

  // address decode, used for both error and read data
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `RDSC_REG_TXDATA) || (a == `RDSC_REG_CFG) || (a == `RDSC_REG_STATUS);
  endfunction

  rdsc_hst_state_t state_q;   // frame sequencer
  rdsc_word_t      tx_q;      // word waiting or in flight
  rdsc_word_t      shift_q;   // bits still to send
  logic            pend_q;    // word written, not yet started
  logic            force_q;   // force enable level
  logic [11:0]     timer_q;   // cycles spent in current state
  logic [11:0]     space_q;   // cycles since last frame start
  logic [3:0]      bits_q;    // bits sent in this frame
  logic [7:0]      frames_q;  // frames sent, wraps
  logic            busy;      // frame pending or in progress
  logic            wr_acc;    // write access phase
  logic            start;     // frame starts this cycle

  // ---------------------------------------------
  // apb slave
  // ---------------------------------------------
  assign wr_acc    = I_PSEL & I_PENABLE & I_PWRITE;
  assign O_PREADY  = 1'b1; // no wait states
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~is_mapped(I_PADDR);
  assign busy      = pend_q | (state_q != RDSC_HST_IDLE);

  // read data is set up during the setup phase
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_PRDATA <= 32'h0000_0000;
    end else if (I_PSEL && !I_PENABLE) begin
      O_PRDATA <= 32'h0000_0000;
      if (I_PADDR == `RDSC_REG_TXDATA) begin
        O_PRDATA[7:0] <= tx_q;
      end else if (I_PADDR == `RDSC_REG_CFG) begin
        O_PRDATA[`RDSC_CFG_FORCE_BIT] <= force_q;
      end else if (is_mapped(I_PADDR)) begin
        O_PRDATA[`RDSC_STAT_BUSY_BIT] <= busy;
        O_PRDATA[`RDSC_STAT_CNT_LSB +: 8] <= frames_q;
      end
    end
  end

  // writes: a word written while busy is dropped, so a
  // frame never changes under the shifter
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      tx_q    <= 8'h00;
      pend_q  <= 1'b0;
      force_q <= 1'b0;
    end else begin
      if (start) begin
        pend_q <= 1'b0;
      end
      if (wr_acc && I_PADDR == `RDSC_REG_TXDATA && !busy) begin
        tx_q   <= I_PWDATA[7:0];
        pend_q <= 1'b1;
      end
      if (wr_acc && I_PADDR == `RDSC_REG_CFG) begin
        force_q <= I_PWDATA[`RDSC_CFG_FORCE_BIT];
      end
    end
  end

  // ---------------------------------------------
  // frame sequencer
  // ---------------------------------------------
  // rewrite spacing
  // starts are held off until 100 us after the last one
  assign start = pend_q && (state_q == RDSC_HST_IDLE) && (space_q >= 12'(`RDSC_SPACING_CYC));

  // spacing counter saturates so an old start never wraps
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      space_q <= 12'(`RDSC_SPACING_CYC);
    end else if (start) begin
      space_q <= 12'h000;
    end else if (space_q < 12'(`RDSC_SPACING_CYC)) begin
      space_q <= space_q + 12'h001;
    end
  end

  // link pins come straight from flops
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_q                <= RDSC_HST_IDLE;
      timer_q                <= 12'h000;
      bits_q                 <= 4'h0;
      shift_q                <= 8'h00;
      frames_q               <= 8'h00;
      LINK.chip_select_n     <= 1'b1;
      LINK.serial_clk        <= 1'b0;
      LINK.serial_data       <= 1'b0;
      LINK.low_side_output_1_force_enable <= 1'b0;
    end else begin
      LINK.low_side_output_1_force_enable <= force_q;
      timer_q                <= timer_q + 12'h001;
      case (state_q)
        RDSC_HST_IDLE: begin
          LINK.serial_clk <= 1'b0;
          if (start) begin
            LINK.chip_select_n <= 1'b0;
            LINK.serial_data   <= tx_q[7];
            shift_q            <= {tx_q[6:0], 1'b0};
            bits_q             <= 4'h0;
            timer_q            <= 12'h001;
            state_q            <= RDSC_HST_LEAD;
          end
        end
        RDSC_HST_LEAD: begin
          if (timer_q >= 12'(`RDSC_LEAD_CYC)) begin
            LINK.serial_clk <= 1'b1;
            timer_q         <= 12'h001;
            state_q         <= RDSC_HST_HIGH;
          end
        end
        RDSC_HST_HIGH: begin
          if (timer_q >= 12'(`RDSC_HALF_CYC)) begin
            // data moves on the falling edge, far from sampling
            LINK.serial_clk  <= 1'b0;
            LINK.serial_data <= shift_q[7];
            shift_q          <= {shift_q[6:0], 1'b0};
            bits_q           <= bits_q + 4'h1;
            timer_q          <= 12'h001;
            if (bits_q == 4'(`RDSC_WORD_BITS - 1)) begin
              state_q <= RDSC_HST_TAIL;
            end else begin
              state_q <= RDSC_HST_LOW;
            end
          end
        end
        RDSC_HST_LOW: begin
          if (timer_q >= 12'(`RDSC_HALF_CYC)) begin
            LINK.serial_clk <= 1'b1;
            timer_q         <= 12'h001;
            state_q         <= RDSC_HST_HIGH;
          end
        end
        RDSC_HST_TAIL: begin
          if (timer_q >= 12'(`RDSC_TAIL_CYC)) begin
            LINK.chip_select_n <= 1'b1;
            frames_q           <= frames_q + 8'h01;
            timer_q            <= 12'h001;
            state_q            <= RDSC_HST_GAP;
          end
        end
        RDSC_HST_GAP: begin
          if (timer_q >= 12'(`RDSC_GAP_CYC)) begin
            state_q <= RDSC_HST_IDLE;
          end
        end
        default: begin
          LINK.chip_select_n <= 1'b1;
          LINK.serial_clk    <= 1'b0;
          state_q            <= RDSC_HST_IDLE;
        end
      endcase
    end
  end
endmodule

// File: verification/rdsc_link_chk.sv
`timescale 1ns/1ps
// ----------------------------------------
// link checker: host timing on the wire
// ----------------------------------------
module rdsc_link_chk (
  input wire logic I_SYS_CLK,
  input wire logic I_ARST_N,
  input wire logic chip_select_n,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic low_side_output_1_force_enable
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_ARST_N);
  logic        sclk_q;  // serial clock one cycle back
  logic        cs_q;    // select one cycle back
  logic [3:0]  bits_q;  // rising clock edges in this frame
  logic [15:0] since_q; // cycles since the last frame start
  // edge history; select resets high so reset makes no start
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
    end else begin
      sclk_q <= serial_clk;
      cs_q   <= chip_select_n;
    end
  end
  // bit count, cleared while deselected
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      bits_q <= 4'h0;
    end else if (chip_select_n) begin
      bits_q <= 4'h0;
    end else if (serial_clk && !sclk_q) begin
      bits_q <= bits_q + 4'h1;
    end
  end
  // start spacing; saturated at reset so the first start is free
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      since_q <= 16'hffff;
    end else if (!chip_select_n && cs_q) begin
      since_q <= 16'h0000;
    end else if (since_q != 16'hffff) begin
      since_q <= since_q + 16'h0001;
    end
  end
  a_sclk_idle_low: assert property (chip_select_n |-> !serial_clk)
    else $error("serial clock high while deselected");
  a_select_lead: assert property ($fell(chip_select_n) |-> !serial_clk ##1 serial_clk)
    else $error("lead time from select to clock wrong");
  a_sclk_high: assert property ($rose(serial_clk) |-> serial_clk [*4] ##1 !serial_clk)
    else $error("serial clock high time wrong");
  a_data_hold: assert property ($rose(serial_clk) |-> $stable(serial_data) [*4])
    else $error("data moved while clock high");
  a_eight_bits: assert property ($rose(chip_select_n) |-> bits_q == 4'h8)
    else $error("frame closed without eight bits");
  a_tail_low: assert property ($rose(chip_select_n) |-> !$past(serial_clk, 1) && !$past(serial_clk, 2))
    else $error("select rose too soon after last clock");
  a_word_gap: assert property ($rose(chip_select_n) |-> chip_select_n [*4])
    else $error("gap between words too short");
  a_frame_close: assert property ($fell(chip_select_n) |-> ##[60:66] $rose(chip_select_n))
    else $error("frame did not close in time");
  a_start_spacing: assert property ($fell(chip_select_n) |-> since_q >= 16'd1999)
    else $error("register rewrites too close");
  c_frame_done: cover property ($rose(chip_select_n) && bits_q == 4'h8);
  c_force_on: cover property ($rose(low_side_output_1_force_enable));
  c_data_one: cover property ($rose(serial_clk) && serial_data);
endmodule

// File: verification/relay_driver_serial_control_tb_top.sv
`timescale 1ns/1ps
`include "rdsc_map.svh"
module relay_driver_serial_control_tb_top
  import rdsc_pkg::*;
;
  // ----------------------------------------
  // rows: word, force level, outputs expected
  // ----------------------------------------
  typedef struct packed {rdsc_word_t wd; logic frc; rdsc_word_t ex;} rdsc_row_t;
  rdsc_row_t   rows [8] = '{'{8'h00, 1'b1, 8'h01}, '{8'hfe, 1'b1, 8'hff}, '{8'h80, 1'b0, 8'h80},
                            '{8'h01, 1'b0, 8'h01}, '{8'ha5, 1'b0, 8'ha5}, '{8'h5a, 1'b1, 8'h5b},
                            '{8'hff, 1'b0, 8'hff}, '{8'h00, 1'b0, 8'h00}};
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, er, ld, fe, ld2, fe2;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  rdsc_word_t  lso, lso2, cap = 8'h00;
  int          cap_base = 0; // capture count before a frame
  int          ld_cnt = 0, fe_cnt = 0, ld2_cnt = 0, fe2_cnt = 0, cap_n = 0, err_total = 0, samples_checked = 0;
  rdsc_if link();
  rdsc_if link2(); // second device, driven by the bench
  rdsc_host u_rdsc_host (.I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .LINK(link.hst));
  rdsc_device u_rdsc_device (.I_SYS_CLK(clk), .I_ARST_N(arst_n), .LINK(link.dev), .O_LOW_SIDE_OUT(lso),
    .O_WORD_LOADED(ld), .O_FRAME_ERR(fe));
  rdsc_device u_rdsc_device_flt (.I_SYS_CLK(clk), .I_ARST_N(arst_n), .LINK(link2.dev), .O_LOW_SIDE_OUT(lso2),
    .O_WORD_LOADED(ld2), .O_FRAME_ERR(fe2));
  rdsc_link_chk u_rdsc_link_chk (.I_SYS_CLK(clk), .I_ARST_N(arst_n), .chip_select_n(link.chip_select_n),
    .serial_clk(link.serial_clk), .serial_data(link.serial_data), .low_side_output_1_force_enable(link.low_side_output_1_force_enable));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // wire capture, msb first, only while selected
  always @(posedge link.serial_clk) begin
    if (link.chip_select_n === 1'b0) begin
      cap <= {cap[6:0], link.serial_data};
      cap_n <= cap_n + 1;
    end
  end
  // pulse counters of both devices
  always @(posedge clk) begin
    if (ld === 1'b1) ld_cnt <= ld_cnt + 1;
    if (fe === 1'b1) fe_cnt <= fe_cnt + 1;
    if (ld2 === 1'b1) ld2_cnt <= ld2_cnt + 1;
    if (fe2 === 1'b1) fe2_cnt <= fe2_cnt + 1;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; an idle edge after it keeps drives one per step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_idle;
    do apb(1'b0, `RDSC_REG_STATUS, 32'h0); while (rd[`RDSC_STAT_BUSY_BIT] !== 1'b0);
  endtask
  task automatic wait_ld(input int tgt);
    repeat (4000) if (ld_cnt < tgt) @(posedge clk);
    @(posedge clk);
  endtask
  // far end in place of the host: clock period 8 cycles, 400 ns
  // lead, tail and gap kept
  task automatic frame2(input rdsc_word_t w, input int nb, input logic sel_n);
    link2.chip_select_n <= sel_n;
    repeat (2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      link2.serial_data <= w[7-i];
      repeat (4) @(posedge clk);
      link2.serial_clk <= 1'b1;
      repeat (4) @(posedge clk);
      link2.serial_clk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    link2.chip_select_n <= 1'b1;
    link2.serial_data <= ~link2.serial_data; // released line shows no stale bit
    repeat (8) @(posedge clk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard, nearly three times the expected run
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    conclude();
  end
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    link2.chip_select_n = 1'b1;
    link2.serial_clk = 1'b0;
    link2.serial_data = 1'b0;
    link2.low_side_output_1_force_enable = 1'b0;
    arst_n = 1'b0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    chk("outputs", lso, 32'h0);
    chk("select", link.chip_select_n, 32'h1);
    chk("clock", link.serial_clk, 32'h0);
    repeat (4) @(posedge clk);
    $display("test reset done");
    foreach (rows[i]) begin
      wait_idle();
      apb(1'b1, `RDSC_REG_CFG, {31'h0, rows[i].frc});
      cap_base = cap_n;
      apb(1'b1, `RDSC_REG_TXDATA, {24'h0, rows[i].wd});
      wait_ld(i + 1);
      chk("outputs", lso, rows[i].ex);
      chk("wire word", cap, rows[i].wd);
      chk("wire bits", 32'(cap_n - cap_base), 32'h8);
      chk("force pin", link.low_side_output_1_force_enable, rows[i].frc);
      chk("idle clock", link.serial_clk, 32'h0);
      apb(1'b0, `RDSC_REG_STATUS, 32'h0);
      chk("frames", rd[15:8], 32'(i + 1));
    end
    $display("test table done");
    wait_idle();
    apb(1'b1, `RDSC_REG_TXDATA, 32'h3c);
    apb(1'b1, `RDSC_REG_TXDATA, 32'hc3);
    apb(1'b0, `RDSC_REG_STATUS, 32'h0);
    chk("busy", rd[`RDSC_STAT_BUSY_BIT], 32'h1);
    apb(1'b0, `RDSC_REG_TXDATA, 32'h0);
    chk("held word", rd, 32'h3c);
    wait_ld(9);
    repeat (2500) @(posedge clk);
    chk("outputs", lso, 32'h3c);
    chk("loads", 32'(ld_cnt), 32'h9);
    apb(1'b0, `RDSC_REG_CFG, 32'h0);
    chk("cfg", rd, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped err", er, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test busy and registers done");
    frame2(8'h96, 8, 1'b0);
    chk("far out", lso2, 32'h96);
    frame2(8'h0f, 7, 1'b0);
    chk("far err", 32'(fe2_cnt), 32'h1);
    chk("far out", lso2, 32'h96);
    frame2(8'h55, 8, 1'b1);
    chk("far out", lso2, 32'h96);
    frame2(8'h69, 8, 1'b0);
    chk("far out", lso2, 32'h69);
    chk("far loads", 32'(ld2_cnt), 32'h2);
    $display("test far end faults done");
    wait_idle();
    apb(1'b1, `RDSC_REG_TXDATA, 32'he7);
    repeat (20) @(posedge clk);
    arst_n <= 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2500) @(posedge clk);
    chk("outputs", lso, 32'h0);
    chk("loads", 32'(ld_cnt), 32'h9);
    chk("frame errs", 32'(fe_cnt), 32'h0);
    $display("test reset mid frame done");
    conclude();
  end
endmodule
